// [src/rcs_pkg.sv]
`default_nettype none
package rcs_pkg;
    // Register addresses of the host port
    localparam logic [4:0] ADDR_CHIP_STATUS_CONTROL = 5'h00;
    localparam logic [4:0] ADDR_PROTOCOL_SELECT     = 5'h01;
    // Reset values
    localparam logic [7:0] CSC_RESET   = 8'h01;
    localparam logic [7:0] PROTO_RESET = 8'h02;
    // Control register field positions
    localparam int BIT_STANDBY        = 7;
    localparam int BIT_BYPASS         = 6;
    localparam int BIT_CARRIER_ON     = 5;
    localparam int BIT_HALF_DRIVE     = 4;
    localparam int BIT_MAIN_INPUT     = 3;
    localparam int BIT_AGC_ON         = 2;
    localparam int BIT_FORCE_RX       = 1;
    localparam int BIT_SUPPLY_RANGE   = 0;
    // Protocol register bypass variant bit
    localparam int BIT_DIRECT_VARIANT = 6;
    // Operating modes seen by the rest of the chip
    typedef enum logic [1:0] {
        RCS_MODE_FRAMED  = 2'b00,
        RCS_MODE_DIRECT0 = 2'b01,
        RCS_MODE_DIRECT1 = 2'b10
    } rcs_mode_t;
endpackage
`default_nettype wire

// [src/rcs_reg8.sv]
`default_nettype none
module rcs_reg8 #(
    parameter logic [7:0] RESET_VAL = 8'h00
) (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rstn,
    // Preset when chip disabled
    input  wire logic       i_preset,
    // Write strobe and data
    input  wire logic       i_we,
    input  wire logic [7:0] i_wdata,
    // Stored value
    output logic      [7:0] o_q
);
    logic [7:0] val_q;  // Stored byte
    logic [7:0] val_d;  // Next byte

    // Preset beats write so disable always restores defaults
    always_comb begin
        val_d = val_q;
        if (i_preset) begin
            val_d = RESET_VAL;
        end else if (i_we) begin
            val_d = i_wdata;
        end
    end

    // Register only
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            val_q <= RESET_VAL;
        end else begin
            val_q <= val_d;
        end
    end

    assign o_q = val_q;
endmodule // rcs_reg8
`default_nettype wire

// [src/rcs_chip_status_control.sv]
// Functional notes
// - Chip disable or reset loads 0x01
// - Bit 7 standby, clock kept running
// - Bit 6 bypasses framing to direct mode
// - Bit 5 turns transmitter and receivers on
// - Bit 4 one selects half drive
// - Bit 2 enables gain control
// - Bit 1 forces receiver and oscillator
// - Bit 0 zero selects 3-volt range
// - Protocol bit 6 picks direct variant
`default_nettype none
module rcs_chip_status_control (
    // Clock and reset
    input  wire logic                 i_mclk,
    input  wire logic                 i_rstn,
    // Chip-activate pin, active high
    input  wire logic                 i_chip_enable,
    // Host register port
    input  wire logic [4:0]           i_addr,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    input  wire logic [7:0]           i_wdata,
    output logic      [7:0]           o_rdata,
    // Decoded controls
    output logic                      o_standby,
    output logic                      o_osc_run,
    output rcs_pkg::rcs_mode_t        o_mode,
    output logic                      o_carrier_output_active,
    output logic                      o_tx_osc_enable,
    output logic                      o_receiver_enable,
    output logic                      o_half_drive_select,
    output logic                      o_main_input_select,
    output logic                      o_agc_enable,
    output logic                      o_supply_range_select
);
    logic       preset;      // Reload defaults
    logic       we_csc;      // Control write strobe
    logic       we_proto;    // Protocol write strobe
    logic [7:0] csc_q;       // Control register
    logic [7:0] proto_q;     // Protocol register
    logic [7:0] rdata_d;     // Next read data
    logic [7:0] rdata_q;     // Read data register

    assign preset   = !i_chip_enable;
    assign we_csc   = i_wr && (i_addr == rcs_pkg::ADDR_CHIP_STATUS_CONTROL);
    assign we_proto = i_wr && (i_addr == rcs_pkg::ADDR_PROTOCOL_SELECT);

    rcs_reg8 #(
        .RESET_VAL (rcs_pkg::CSC_RESET)
    ) u_csc (
        .i_mclk   (i_mclk),
        .i_rstn   (i_rstn),
        .i_preset (preset),
        .i_we     (we_csc),
        .i_wdata  (i_wdata),
        .o_q      (csc_q)
    );

    rcs_reg8 #(
        .RESET_VAL (rcs_pkg::PROTO_RESET)
    ) u_proto (
        .i_mclk   (i_mclk),
        .i_rstn   (i_rstn),
        .i_preset (preset),
        .i_we     (we_proto),
        .i_wdata  (i_wdata),
        .o_q      (proto_q)
    );

    always_comb begin
        rdata_d = rdata_q;
        if (i_rd) begin
            unique case (i_addr)
                rcs_pkg::ADDR_CHIP_STATUS_CONTROL: rdata_d = csc_q;
                rcs_pkg::ADDR_PROTOCOL_SELECT:     rdata_d = proto_q;
                default:                           rdata_d = 8'h00;
            endcase
        end
    end

    // Read data register
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end
    assign o_rdata = rdata_q;

    assign o_standby = csc_q[rcs_pkg::BIT_STANDBY];
    assign o_osc_run = 1'b1;

    always_comb begin
        if (!csc_q[rcs_pkg::BIT_BYPASS]) begin
            o_mode = rcs_pkg::RCS_MODE_FRAMED;
        end else if (proto_q[rcs_pkg::BIT_DIRECT_VARIANT]) begin
            o_mode = rcs_pkg::RCS_MODE_DIRECT1;
        end else begin
            o_mode = rcs_pkg::RCS_MODE_DIRECT0;
        end
    end

    assign o_carrier_output_active = csc_q[rcs_pkg::BIT_CARRIER_ON];
    // forced receive path for field checks
    assign o_receiver_enable = csc_q[rcs_pkg::BIT_CARRIER_ON]
                             | csc_q[rcs_pkg::BIT_FORCE_RX];
    assign o_tx_osc_enable   = o_receiver_enable;
    assign o_half_drive_select   = csc_q[rcs_pkg::BIT_HALF_DRIVE];
    assign o_main_input_select   = csc_q[rcs_pkg::BIT_MAIN_INPUT];
    assign o_agc_enable          = csc_q[rcs_pkg::BIT_AGC_ON];
    // supply range, zero is 3 V
    assign o_supply_range_select = csc_q[rcs_pkg::BIT_SUPPLY_RANGE];

    property p_preset;
        @(posedge i_mclk) disable iff (!i_rstn)
        !i_chip_enable |=> (csc_q == rcs_pkg::CSC_RESET);
    endproperty
    a_preset: assert property (p_preset) else $error("no preset");

    // write, one quiet cycle, then read returns the byte
    // Host scrambles data after release, so a stale sample would show
    property p_readback;
        @(posedge i_mclk) disable iff (!i_rstn)
        (we_csc && i_chip_enable)
        ##1 (!we_csc && i_chip_enable)
        ##1 (i_rd && !i_wr && i_chip_enable
            && i_addr == rcs_pkg::ADDR_CHIP_STATUS_CONTROL)
        |=> (o_rdata == $past(i_wdata, 3));
    endproperty
    a_readback: assert property (p_readback) else $error("readback");

    // receiver and oscillator follow carrier or force
    // Checked against the written byte, not the stored copy
    property p_rx;
        @(posedge i_mclk) disable iff (!i_rstn)
        (we_csc && i_chip_enable)
        |=> (o_receiver_enable
                == ($past(i_wdata[rcs_pkg::BIT_CARRIER_ON])
                    | $past(i_wdata[rcs_pkg::BIT_FORCE_RX])))
            && (o_tx_osc_enable == o_receiver_enable);
    endproperty
    a_rx: assert property (p_rx) else $error("rx enable");

    property p_mode;
        @(posedge i_mclk) disable iff (!i_rstn)
        (we_csc && i_chip_enable && !i_wdata[6])
        |=> (o_mode == rcs_pkg::RCS_MODE_FRAMED);
    endproperty
    a_mode: assert property (p_mode) else $error("mode");

    property p_carrier;
        @(posedge i_mclk) disable iff (!i_rstn)
        (we_csc && i_chip_enable)
        |=> (o_carrier_output_active == $past(i_wdata[5]));
    endproperty
    a_carrier: assert property (p_carrier) else $error("carrier");

    // standby follows bit, oscillator keeps running
    property p_standby;
        @(posedge i_mclk) disable iff (!i_rstn)
        (we_csc && i_chip_enable)
        |=> (o_standby == $past(i_wdata[rcs_pkg::BIT_STANDBY]))
            && o_osc_run;
    endproperty
    a_standby: assert property (p_standby) else $error("standby");

    property p_drive;
        @(posedge i_mclk) disable iff (!i_rstn)
        (we_csc && i_chip_enable)
        |=> (o_half_drive_select
                == $past(i_wdata[rcs_pkg::BIT_HALF_DRIVE]));
    endproperty
    a_drive: assert property (p_drive) else $error("drive level");

    property p_input;
        @(posedge i_mclk) disable iff (!i_rstn)
        (we_csc && i_chip_enable)
        |=> (o_main_input_select
                == $past(i_wdata[rcs_pkg::BIT_MAIN_INPUT]));
    endproperty
    a_input: assert property (p_input) else $error("input select");

    property p_agc;
        @(posedge i_mclk) disable iff (!i_rstn)
        (we_csc && i_chip_enable)
        |=> (o_agc_enable == $past(i_wdata[rcs_pkg::BIT_AGC_ON]));
    endproperty
    a_agc: assert property (p_agc) else $error("gain control");

    property p_supply;
        @(posedge i_mclk) disable iff (!i_rstn)
        (we_csc && i_chip_enable)
        |=> (o_supply_range_select
                == $past(i_wdata[rcs_pkg::BIT_SUPPLY_RANGE]));
    endproperty
    a_supply: assert property (p_supply) else $error("supply");

    // Main scenarios: direct variant, standby, forced receive, preset
    c_direct1: cover property (@(posedge i_mclk)
        o_mode == rcs_pkg::RCS_MODE_DIRECT1);
    c_standby: cover property (@(posedge i_mclk) o_standby);
    c_force: cover property (@(posedge i_mclk)
        o_receiver_enable && !o_carrier_output_active);
    // Preset overriding a host write in the same cycle
    c_preset: cover property (@(posedge i_mclk)
        !i_chip_enable && i_wr);
endmodule // rcs_chip_status_control
`default_nettype wire

// [tb/rcs_host_model.sv]
`default_nettype none
// Host side of the register port
module rcs_host_model (
    // Clock
    input  wire logic       i_mclk,
    // Host port towards the device
    output var  logic [4:0] o_addr,
    output var  logic       o_wr,
    output var  logic       o_rd,
    output var  logic [7:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle port at time zero
    initial begin
        o_addr = 5'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 8'h00;
    end
    // One-cycle write; data scrambled after release
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_mclk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask
    // One-cycle read strobe
    task automatic rd_reg(input logic [4:0] a);
        @(posedge i_mclk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_mclk);
        o_rd <= 1'b0;
    endtask
endmodule // rcs_host_model
`default_nettype wire

// [tb/rcs_chip_status_control_test.sv]
`default_nettype none
module rcs_chip_status_control_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk = 1'b0;    // 100 MHz
    logic       rstn = 1'b0;    // Held low at start
    logic       chip_en = 1'b1; // Chip-activate pin
    logic [4:0] addr;
    logic       wr, rd;
    logic [7:0] wdata, rdata, v;
    logic       stby, osc, car, txo, rxe, half, mainin, agc, sup;
    rcs_pkg::rcs_mode_t mode;
    int         num_errors = 0, checks = 0;
    // Clock
    always #5 mclk = ~mclk;
    rcs_host_model HOST (.i_mclk(mclk), .o_addr(addr), .o_wr(wr),
        .o_rd(rd), .o_wdata(wdata));
    rcs_chip_status_control DUT (.i_mclk(mclk), .i_rstn(rstn),
        .i_chip_enable(chip_en), .i_addr(addr), .i_wr(wr), .i_rd(rd),
        .i_wdata(wdata), .o_rdata(rdata), .o_standby(stby),
        .o_osc_run(osc), .o_mode(mode), .o_carrier_output_active(car),
        .o_tx_osc_enable(txo), .o_receiver_enable(rxe),
        .o_half_drive_select(half), .o_main_input_select(mainin),
        .o_agc_enable(agc), .o_supply_range_select(sup));
    // Count and report one comparison
    task automatic chk(input string n, input logic [11:0] e,
                       input logic [11:0] g);
        checks++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // Decoded controls from value c, variant p
    task automatic ctl(input logic [7:0] c, input logic p);
        logic [1:0] m;
        m = !c[6] ? 2'b00 : (p ? 2'b10 : 2'b01);
        chk("controls", {1'b0, c[7], 1'b1, m, c[5], c[5] | c[1],
            c[5] | c[1], c[4], c[3], c[2], c[0]}, {1'b0, stby, osc,
            mode, car, txo, rxe, half, mainin, agc, sup});
    endtask
    // Read one register and compare
    task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
        HOST.rd_reg(a);
        #1;
        chk("rdata", {4'h0, e}, {4'h0, rdata});
    endtask
    // Print counts and verdict, then stop
    task automatic give_verdict;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        #1;
        ctl(8'h01, 1'b0);
        rdchk(5'h00, 8'h01);
        // Walking ones, then all set, then all clear
        for (int i = 0; i < 10; i++) begin
            v = (i < 8) ? (8'h01 << i) : ((i == 8) ? 8'hff : 8'h00);
            HOST.wr_reg(5'h00, v);
            #1;
            ctl(v, 1'b0);
            rdchk(5'h00, v);
        end
        // Variant chosen before bypass bit
        HOST.wr_reg(5'h01, 8'h42);
        HOST.wr_reg(5'h00, 8'h40);
        #1;
        ctl(8'h40, 1'b1);
        HOST.wr_reg(5'h01, 8'h02);
        #1;
        ctl(8'h40, 1'b0);
        // Chip disabled: preset wins over a write
        @(posedge mclk);
        chip_en <= 1'b0;
        HOST.wr_reg(5'h00, 8'hfe);
        #1;
        ctl(8'h01, 1'b0);
        @(posedge mclk);
        chip_en <= 1'b1;
        rdchk(5'h00, 8'h01);
        // Unmapped place reads zero, control untouched
        HOST.wr_reg(5'h05, 8'h5a);
        rdchk(5'h05, 8'h00);
        rdchk(5'h00, 8'h01);
        // Reset in mid-run restores the default
        HOST.wr_reg(5'h00, 8'h3c);
        #1;
        ctl(8'h3c, 1'b0);
        @(posedge mclk);
        rstn <= 1'b0;
        #1;
        chk("rdata", 12'h000, {4'h0, rdata});
        ctl(8'h01, 1'b0);
        @(posedge mclk);
        rstn <= 1'b1;
        rdchk(5'h00, 8'h01);
        give_verdict();
    end
    // Watchdog, far beyond the roughly 70 cycles needed
    initial begin
        repeat (2000) @(posedge mclk);
        num_errors++;
        $display("[FAIL] watchdog expected finish seen timeout");
        give_verdict();
    end
endmodule // rcs_chip_status_control_test
`default_nettype wire
